// ### rtl/sdram_pkg.sv
// shared constants, command encodings and pin bundle for the sdram device
`default_nettype none
package sdram_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // refresh cycle, a least time: rounds up
  localparam int TRC_NS = 48;
  localparam int TRC_CYC = (TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // clock enable recovery, one clock plus 3 ns
  localparam int CKA_NS = 8;
  localparam int CKA_CYC = (CKA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // self refresh spacing, 64 ms over 4096 rows, a longest time: rounds down
  localparam int SREF_INT_NS = 15625;
  localparam int SREF_INT_CYC = SREF_INT_NS / CLK_PERIOD_NS;
  localparam int ROWS_PER_BANK = 4096;
  localparam int TMR_W = 4;
  localparam int SREF_W = 12;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int ADDR_W = 12;
  localparam int ROW_W = 11;
  localparam int COL_W = 10;
  localparam int BLEN_W = 9;
  localparam int auto_precharge_addr_bit = 10;
  localparam int bank_select_addr_bit = 11;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] REF_ROW_RESET = 12'h000;
  localparam logic [2:0] CL_THREE = 3'h3;

  typedef enum {
    nop_cmd, device_deselect_cmd, mode_load_cmd, activate_cmd,
    precharge_cmd, read_cmd, burst_write_cmd, burst_terminate_cmd,
    refresh_cmd
  } cmd_e;

  typedef enum {
    normal_st, refreshing_st, self_refresh_st, power_down_st,
    suspend_st, recover_st
  } dev_state_e;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [LANES-1:0] dqm;
    logic [ADDR_W-1:0] addr;
  } sdram_cmd_s;

  function automatic cmd_e decode(input sdram_cmd_s c);
    if (c.cs_n) return device_deselect_cmd;
    unique case ({c.ras_n, c.cas_n, c.we_n})
      3'b000: return mode_load_cmd;
      3'b001: return refresh_cmd;
      3'b010: return precharge_cmd;
      3'b011: return activate_cmd;
      3'b100: return burst_write_cmd;
      3'b101: return read_cmd;
      3'b110: return burst_terminate_cmd;
      default: return nop_cmd;
    endcase
  endfunction

  // codes outside 1, 2, 4, 8 and full page act as a single word
  function automatic logic [BLEN_W-1:0] burst_len(input logic [2:0] f);
    unique case (f)
      3'h1: return 9'h002;
      3'h2: return 9'h004;
      3'h3: return 9'h008;
      3'h7: return 9'h100;
      default: return 9'h001;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### rtl/sdram_cmd_device.sv
// command-level model of a two-bank synchronous dram behind its pins
`default_nettype none
// Overview of operation
// - mode load captures all twelve address bits
// - activate opens row in selected bank
// - precharge one bank, or both when flagged
// - read bursts from column, data after latency
// - read with auto-precharge closes bank after burst
// - write with auto-precharge closes bank after burst
// - auto-refresh uses internal row counter, banks idle
// - refresh holds device busy, then returns idle
// - refresh with clock enable low enters self-refresh
// - burst stop ends any burst in progress
// - no-op and deselect change nothing
// - clock enable low idles device in power-down
// - clock enable low mid-burst freezes internal state
module sdram_cmd_device #(
  parameter int MEM_ROW_BITS = 2,
  parameter int MEM_COL_BITS = 8
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire sdram_pkg::sdram_cmd_s CMD_I,
  input wire logic [sdram_pkg::DATA_W-1:0] DQ_I,
  output logic [sdram_pkg::DATA_W-1:0] DQ_O,
  output logic DQ_OE_O,
  output logic [1:0] BANK_OPEN_O,
  output logic [sdram_pkg::ADDR_W-1:0] MODE_O,
  output logic [sdram_pkg::ADDR_W-1:0] REFRESH_ROW_O,
  output logic BUSY_O
);
  import sdram_pkg::*;
  localparam int MEM_AW = 1 + MEM_ROW_BITS + MEM_COL_BITS;
  logic cke_prev_reg, clk_en, take, cmd_bank, cmd_ap, adv, burst_last;
  cmd_e cmd_now;
  dev_state_e state_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [SREF_W-1:0] sref_tmr_reg;
  logic [ADDR_W-1:0] mode_reg, ref_row_reg;
  logic [1:0] open_reg, buf_cnt_reg, pipe_vld;
  logic [ROW_W-1:0] row_reg [2];
  logic [BLEN_W-1:0] blen, burst_cnt_reg;
  logic [2:0] cl_eff;
  logic burst_active_reg, burst_wr_reg, burst_ap_reg, burst_bank_reg;
  logic [COL_W-1:0] burst_col_reg;
  logic [DATA_W-1:0] mem [2**MEM_AW];
  logic [MEM_AW-1:0] cmd_idx, burst_idx;
  logic [DATA_W-1:0] buf_data [2], pipe_data [2];
  logic buf_wr_ptr_reg, buf_rd_ptr_reg, buf_in_ready, buf_out_valid;
  logic push, pop, ins_at_one;

  // internal clock runs only when clock enable was high one edge before
  assign clk_en = cke_prev_reg;
  assign cmd_now = decode(CMD_I);
  assign take = clk_en && state_reg == normal_st && !CMD_I.cs_n;
  assign cmd_bank = CMD_I.addr[bank_select_addr_bit];
  assign cmd_ap = CMD_I.addr[auto_precharge_addr_bit];
  assign blen = burst_len(mode_reg[MODE_BL_LSB +: 3]);
  assign cl_eff = (mode_reg[MODE_CL_LSB +: 3] == CL_THREE) ? 3'h3 : 3'h2;
  assign ins_at_one = cl_eff == CL_THREE;
  // only the low row and column bits reach the reduced storage array
  assign cmd_idx = {cmd_bank, row_reg[cmd_bank][MEM_ROW_BITS-1:0],
                    CMD_I.addr[MEM_COL_BITS-1:0]};
  assign burst_idx = {burst_bank_reg,
                      row_reg[burst_bank_reg][MEM_ROW_BITS-1:0],
                      burst_col_reg[MEM_COL_BITS-1:0]};
  // a read word may only be fetched when the buffer has room
  assign adv = clk_en && burst_active_reg && (burst_wr_reg || buf_in_ready)
               && (state_reg == normal_st || state_reg == recover_st);
  assign burst_last = burst_cnt_reg == 9'h001;
  assign buf_in_ready = buf_cnt_reg != 2'h2;
  assign buf_out_valid = buf_cnt_reg != 2'h0;
  assign push = adv && !burst_wr_reg;
  assign pop = buf_out_valid && clk_en;
  assign BANK_OPEN_O = open_reg;
  assign MODE_O = mode_reg;
  assign REFRESH_ROW_O = ref_row_reg;
  assign BUSY_O = state_reg != normal_st;
  assign DQ_O = pipe_data[0];
  assign DQ_OE_O = pipe_vld[0];
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) cke_prev_reg <= 1'b0;
    else cke_prev_reg <= CMD_I.cke;
  end
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) mode_reg <= MODE_RESET;
    else if (take && cmd_now == mode_load_cmd) mode_reg <= CMD_I.addr;
  end
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= normal_st;
      tmr_reg <= '0;
    end else begin
      unique case (state_reg)
        normal_st: begin
          if (clk_en && !CMD_I.cke) begin
            if (take && cmd_now == refresh_cmd) state_reg <= self_refresh_st;
            else if (burst_active_reg) state_reg <= suspend_st;
            else state_reg <= power_down_st;
          end else if (take && cmd_now == refresh_cmd) begin
            state_reg <= refreshing_st;
            tmr_reg <= TMR_W'(TRC_CYC - 1);
          end
        end
        refreshing_st: begin
          if (tmr_reg == '0) state_reg <= normal_st;
          else tmr_reg <= tmr_reg - 1'b1;
        end
        self_refresh_st: begin
          if (CMD_I.cke) begin
            state_reg <= refreshing_st;
            tmr_reg <= TMR_W'(TRC_CYC - 1);
          end
        end
        power_down_st, suspend_st: begin
          if (CMD_I.cke) begin
            state_reg <= recover_st;
            tmr_reg <= TMR_W'(CKA_CYC - 1);
          end
        end
        recover_st: begin
          if (tmr_reg == '0) state_reg <= normal_st;
          else tmr_reg <= tmr_reg - 1'b1;
        end
      endcase
    end
  end
  // internal refresh address; self-refresh paces itself
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_row_reg <= REF_ROW_RESET;
      sref_tmr_reg <= '0;
    end else if (take && cmd_now == refresh_cmd) begin
      ref_row_reg <= ref_row_reg + 1'b1;
      sref_tmr_reg <= '0;
    end else if (state_reg == self_refresh_st) begin
      if (sref_tmr_reg == SREF_W'(SREF_INT_CYC - 1)) begin
        sref_tmr_reg <= '0;
        ref_row_reg <= ref_row_reg + 1'b1;
      end else begin
        sref_tmr_reg <= sref_tmr_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      open_reg <= 2'h0;
      row_reg[0] <= '0;
      row_reg[1] <= '0;
    end else begin
      if (take && cmd_now == activate_cmd) begin
        open_reg[cmd_bank] <= 1'b1;
        row_reg[cmd_bank] <= CMD_I.addr[ROW_W-1:0];
      end else if (take && cmd_now == precharge_cmd) begin
        if (cmd_ap) open_reg <= 2'h0;
        else open_reg[cmd_bank] <= 1'b0;
      end else if (take && cmd_now == burst_write_cmd && cmd_ap
                   && blen == 9'h001) begin
        open_reg[cmd_bank] <= 1'b0;
      end
      if (adv && burst_last && burst_ap_reg) begin
        open_reg[burst_bank_reg] <= 1'b0;
      end
    end
  end
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      burst_active_reg <= 1'b0;
      burst_wr_reg <= 1'b0;
      burst_ap_reg <= 1'b0;
      burst_bank_reg <= 1'b0;
      burst_col_reg <= '0;
      burst_cnt_reg <= '0;
    end else if (take && (cmd_now == read_cmd
                          || cmd_now == burst_write_cmd)) begin
      burst_wr_reg <= cmd_now == burst_write_cmd;
      burst_ap_reg <= cmd_ap;
      burst_bank_reg <= cmd_bank;
      if (cmd_now == burst_write_cmd) begin
        // first write word is taken with the command itself
        burst_active_reg <= blen != 9'h001;
        burst_col_reg <= CMD_I.addr[COL_W-1:0] + 1'b1;
        burst_cnt_reg <= blen - 1'b1;
      end else begin
        burst_active_reg <= 1'b1;
        burst_col_reg <= CMD_I.addr[COL_W-1:0];
        burst_cnt_reg <= blen;
      end
    end else if (take && (cmd_now == burst_terminate_cmd
                 || (cmd_now == precharge_cmd
                     && (cmd_ap || cmd_bank == burst_bank_reg)))) begin
      burst_active_reg <= 1'b0;
    end else if (adv) begin
      burst_col_reg <= burst_col_reg + 1'b1;
      burst_cnt_reg <= burst_cnt_reg - 1'b1;
      if (burst_last) burst_active_reg <= 1'b0;
    end
  end
  // storage has no reset; dqm high masks a byte lane
  always_ff @(posedge MCLK_I) begin
    for (int l = 0; l < LANES; l++) begin
      if (take && cmd_now == burst_write_cmd && !CMD_I.dqm[l]) begin
        mem[cmd_idx][l*8 +: 8] <= DQ_I[l*8 +: 8];
      end else if (adv && burst_wr_reg && !CMD_I.dqm[l]) begin
        mem[burst_idx][l*8 +: 8] <= DQ_I[l*8 +: 8];
      end
    end
  end
  // two-entry read buffer; drain stalls while the clock is suspended
  always_ff @(posedge MCLK_I) begin
    if (push) buf_data[buf_wr_ptr_reg] <= mem[burst_idx];
  end
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (push) buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
      if (pop) buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // latency line: the word enters nearer the pins for shorter latency
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pipe_vld <= 2'h0;
      pipe_data[0] <= '0;
      pipe_data[1] <= '0;
    end else if (clk_en) begin
      pipe_vld[1] <= pop && ins_at_one;
      pipe_data[1] <= buf_data[buf_rd_ptr_reg];
      pipe_vld[0] <= ins_at_one ? pipe_vld[1] : pop;
      pipe_data[0] <= ins_at_one ? pipe_data[1] : buf_data[buf_rd_ptr_reg];
    end
  end

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  mode_capture_a: assert property (take && cmd_now == mode_load_cmd |=>
    MODE_O == $past(CMD_I.addr)) else $error("mode not captured");
  activate_open_a: assert property (take && cmd_now == activate_cmd |=>
    BANK_OPEN_O[$past(cmd_bank)]) else $error("bank not opened");
  precharge_all_a: assert property (take && cmd_now == precharge_cmd
    && cmd_ap |=> BANK_OPEN_O == 2'h0) else $error("banks left open");
  read_latency_a: assert property (take && cmd_now == read_cmd
    && cl_eff == 3'h2 && CMD_I.cke ##1 CMD_I.cke |=> ##1 DQ_OE_O)
    else $error("read data late");
  rd_autoclose_a: assert property (adv && burst_last && burst_ap_reg
    && !burst_wr_reg |=> !BANK_OPEN_O[$past(burst_bank_reg)])
    else $error("read autoprecharge missed");
  wr_autoclose_a: assert property (adv && burst_last && burst_ap_reg
    && burst_wr_reg |=> !BANK_OPEN_O[$past(burst_bank_reg)])
    else $error("write autoprecharge missed");
  refresh_busy_a: assert property (take && cmd_now == refresh_cmd
    && CMD_I.cke && !CMD_I.cs_n |=> BUSY_O [*8] ##1 BUSY_O ##1 BUSY_O
    ##1 (!BUSY_O || state_reg != refreshing_st))
    else $error("refresh period wrong");
  self_ref_a: assert property (take && cmd_now == refresh_cmd
    && !CMD_I.cke |=> state_reg == self_refresh_st ##1
    (state_reg == self_refresh_st || CMD_I.cke || $past(CMD_I.cke)))
    else $error("self refresh not entered");
  burst_stop_a: assert property (take && cmd_now == burst_terminate_cmd
    |=> !burst_active_reg) else $error("burst not stopped");
  nop_still_a: assert property ((take && cmd_now == nop_cmd
    || CMD_I.cs_n) && !burst_active_reg && state_reg == normal_st
    |=> $stable(BANK_OPEN_O) && $stable(MODE_O))
    else $error("state changed on idle command");
  power_down_a: assert property (state_reg == normal_st && clk_en
    && !CMD_I.cke && !burst_active_reg && !(take && cmd_now == refresh_cmd)
    |=> state_reg == power_down_st) else $error("no power down");
  suspend_hold_a: assert property (state_reg == suspend_st
    && !clk_en |=> $stable(burst_col_reg) && $stable(DQ_O)
    && $stable(buf_cnt_reg)) else $error("suspend not frozen");

  read_burst_c: cover property (take && cmd_now == read_cmd ##[1:6] DQ_OE_O);
  write_ap_c: cover property (adv && burst_last && burst_ap_reg
    && burst_wr_reg);
  self_ref_c: cover property (state_reg == self_refresh_st
    ##[1:20] state_reg == refreshing_st);
  suspend_c: cover property (state_reg == suspend_st
    ##[1:20] state_reg == recover_st);
endmodule // sdram_cmd_device
`default_nettype wire

// ### tb/sdram_ctrl_model.sv
// controller model driving command pins and write data
`default_nettype none
module sdram_ctrl_model (
  input wire logic clk_i,
  output sdram_pkg::sdram_cmd_s cmd_o,
  output logic [sdram_pkg::DATA_W-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_pkg::*;
  logic [DATA_W-1:0] last_dq;
  initial begin
    cmd_o = {5'h1f, 14'h0000};
    last_dq = 16'h0000;
    dq_o = 16'h0000;
  end
  // deselect carries the activate strobes, so a leak would show
  function automatic logic [2:0] code(input cmd_e c);
    case (c)
      mode_load_cmd: return 3'h0;
      refresh_cmd: return 3'h1;
      precharge_cmd: return 3'h2;
      activate_cmd, device_deselect_cmd: return 3'h3;
      burst_write_cmd: return 3'h4;
      read_cmd: return 3'h5;
      burst_terminate_cmd: return 3'h6;
      default: return 3'h7;
    endcase
  endfunction
  // released data line toggles so a stale word is never mistaken
  task automatic send(input cmd_e c, input logic [11:0] a,
                      input logic k, input logic wr, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    cmd_o.cke = k;
    cmd_o.cs_n = (c == device_deselect_cmd);
    {cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} = code(c);
    cmd_o.addr = a;
    dq_o = wr ? d : ~last_dq;
    last_dq = dq_o;
  endtask
  task automatic nop(input int n, input logic k);
    repeat (n) send(nop_cmd, 12'h000, k, 1'b0, 16'h0000);
  endtask
  task automatic mode_load(input logic [11:0] a);
    send(mode_load_cmd, a, 1'b1, 1'b0, 16'h0000);
    nop(2, 1'b1);
  endtask
  // four idle cycles cover both activate-to-column and precharge waits
  task automatic row_cmd(input cmd_e c, input logic [11:0] a);
    send(c, a, 1'b1, 1'b0, 16'h0000);
    nop(4, 1'b1);
  endtask
  task automatic wr_burst(input logic [11:0] a, input int n,
                          input logic [15:0] b);
    send(burst_write_cmd, a, 1'b1, 1'b1, b);
    for (int i = 1; i < n; i++)
      send(nop_cmd, 12'h000, 1'b1, 1'b1, b + 16'(i));
    nop(4, 1'b1);
  endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// ### tb/sdram_command_state_logic_test.sv
// self-checking bench for the sdram command device
`default_nettype none
module sdram_command_state_logic_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sdram_cmd_s cmd;
  logic [DATA_W-1:0] dq_in;
  logic [DATA_W-1:0] dq_out;
  logic dq_oe;
  logic busy;
  logic [1:0] open_banks;
  logic [ADDR_W-1:0] mode;
  logic [ADDR_W-1:0] ref_row;
  int fail_count = 0;
  int comparisons = 0;
  int first;
  int cnt;
  int hi;
  logic [15:0] rw [0:15];

  always #2.5 clk = ~clk;

  sdram_ctrl_model m (.clk_i(clk), .cmd_o(cmd), .dq_o(dq_in));
  sdram_cmd_device u_dut (
    .MCLK_I(clk), .RST_I(rst), .CMD_I(cmd), .DQ_I(dq_in),
    .DQ_O(dq_out), .DQ_OE_O(dq_oe), .BANK_OPEN_O(open_banks),
    .MODE_O(mode), .REFRESH_ROW_O(ref_row), .BUSY_O(busy)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // collects every driven word; first is the cycle of the first one
  task automatic rd(input logic [11:0] a, input int n, input logic stop);
    m.send(read_cmd, a, 1'b1, 1'b0, 16'h0000);
    first = 0;
    cnt = 0;
    for (int k = 1; k <= n; k++) begin
      if (stop && k == 1)
        m.send(burst_terminate_cmd, 12'h000, 1'b1, 1'b0, 16'h0000);
      else
        m.nop(1, 1'b1);
      if (dq_oe === 1'b1) begin
        if (first == 0) first = k;
        rw[cnt] = dq_out;
        cnt++;
      end
    end
  endtask

  // counts busy cycles; an activate at step act must be ignored
  task automatic busy_win(input int n, input int act, output int h);
    h = 0;
    for (int i = 0; i < n; i++) begin
      if (i == act)
        m.send(activate_cmd, 12'h000, 1'b1, 1'b0, 16'h0000);
      else
        m.nop(1, 1'b1);
      if (busy === 1'b1) h++;
    end
  endtask

  task automatic t_idle;
    m.send(device_deselect_cmd, 12'h000, 1'b1, 1'b0, 16'h0000);
    m.send(burst_terminate_cmd, 12'h000, 1'b1, 1'b0, 16'h0000);
    m.nop(2, 1'b1);
    check({dq_oe, open_banks, mode, ref_row, busy}, 0);
  endtask

  task automatic t_mode_bank;
    m.mode_load(12'hc5a);
    check(mode, 12'hc5a);
    m.row_cmd(activate_cmd, 12'h7ff);
    check(open_banks, 2'h1);
    m.row_cmd(activate_cmd, 12'h801);
    check(open_banks, 2'h3);
    m.row_cmd(precharge_cmd, 12'h800);
    check(open_banks, 2'h1);
    m.row_cmd(activate_cmd, 12'h800);
    m.row_cmd(precharge_cmd, 12'h400);
    check(open_banks, 2'h0);
  endtask

  task automatic t_rw(input logic [11:0] md, input int cl);
    m.mode_load(md);
    m.row_cmd(activate_cmd, 12'h001);
    m.wr_burst(12'h005, 2, 16'ha500);
    rd(12'h005, 8, 1'b0);
    check(first, cl + 1);
    check(cnt, 2);
    check({rw[0], rw[1]}, {16'ha500, 16'ha501});
    check(open_banks, 2'h1);
    rd(12'h405, 8, 1'b0);
    check(open_banks, 2'h0);
    m.row_cmd(activate_cmd, 12'h001);
    m.wr_burst(12'h406, 2, 16'h5a00);
    check(open_banks, 2'h0);
  endtask

  task automatic t_burst;
    logic [15:0] held;
    m.mode_load(12'h023);
    m.row_cmd(activate_cmd, 12'h001);
    m.wr_burst(12'h000, 8, 16'hc000);
    rd(12'h000, 12, 1'b0);
    check(cnt, 8);
    rd(12'h000, 12, 1'b1);
    check(cnt > 0 && cnt < 4, 1'b1);
    m.send(read_cmd, 12'h000, 1'b1, 1'b0, 16'h0000);
    m.nop(4, 1'b1);
    m.nop(2, 1'b0);
    held = dq_out;
    m.nop(3, 1'b0);
    check({busy, dq_out}, {1'b1, held});
    for (int i = 0; i < 14; i++) begin
      m.nop(1, 1'b1);
      if (dq_oe === 1'b1) held = dq_out;
    end
    check(held, 16'hc007);
  endtask

  // power-down kept short, well inside the refresh period
  task automatic t_power;
    m.nop(1, 1'b0);
    m.send(activate_cmd, 12'h800, 1'b0, 1'b0, 16'h0000);
    m.nop(2, 1'b0);
    check({busy, open_banks}, 3'h5);
    busy_win(6, 99, hi);
    check(hi > 0 && hi <= CKA_CYC + 1, 1'b1);
    m.nop(2, 1'b1);
    check(open_banks, 2'h1);
  endtask

  task automatic t_refresh;
    logic [ADDR_W-1:0] row0;
    m.row_cmd(precharge_cmd, 12'h400);
    row0 = ref_row;
    m.send(refresh_cmd, 12'h000, 1'b1, 1'b0, 16'h0000);
    busy_win(14, 3, hi);
    check(hi, TRC_CYC);
    check({open_banks, ref_row}, {2'h0, row0 + 12'h001});
    m.send(refresh_cmd, 12'h000, 1'b0, 1'b0, 16'h0000);
    m.nop(6, 1'b0);
    check(busy, 1'b1);
    busy_win(16, 3, hi);
    check(hi >= TRC_CYC && hi <= TRC_CYC + 2, 1'b1);
    check(open_banks, 2'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    m.nop(2, 1'b1);
    t_idle();
    t_mode_bank();
    t_rw(12'h021, 2);
    t_rw(12'h031, 3);
    t_burst();
    t_power();
    t_refresh();
    final_report();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #25000;
    fail_count++;
    final_report();
  end
endmodule // sdram_command_state_logic_test
`default_nettype wire
